// ==== rtl/mmsb_defines.svh ====
`ifndef MMSB_DEFINES_SVH
`define MMSB_DEFINES_SVH
// ****************************************
// processor mode encodings (erased bits read as ones)
// ****************************************
`define MMSB_MODE_MICRO_PROC  2'h3
`define MMSB_MODE_MICRO_CTRL  2'h2
`define MMSB_MODE_EXTENDED    2'h1
`define MMSB_MODE_PROTECTED   2'h0
// ****************************************
// program memory map
// ****************************************
`define MMSB_INT_PROG_WORDS   16'h0800
`define MMSB_CFG_BASE         16'hFE00
// ****************************************
// data memory map
// ****************************************
`define MMSB_PERIPH_MAX       8'h1F
`define MMSB_FILE_MAX         8'hFF
`define MMSB_PTR0_ADDR        8'h01
`define MMSB_PTR1_ADDR        8'h09
`define MMSB_INDIR0_ADDR      8'h00
`define MMSB_INDIR1_ADDR      8'h08
`define MMSB_BANKSEL_ADDR     8'h0F
`define MMSB_CTL_BANK_LO      8'h10
`define MMSB_CTL_BANK_HI      8'h17
`define MMSB_SCRATCH_BASE     8'h20
`define MMSB_CTL_BANK_BASE    9'h100
`define MMSB_RAM_WORDS        512
`define MMSB_RAM_BANK_BIT     4
`define MMSB_BANKSEL_RST      8'h00
`define MMSB_PTR_RST          8'h00
`define MMSB_WORD_RST         16'h0000
`endif

// ==== rtl/mmsb_pkg.sv ====
`include "mmsb_defines.svh"
package mmsb_pkg;
  typedef enum logic [1:0] {
    mode_micro_proc = `MMSB_MODE_MICRO_PROC,
    mode_micro_ctrl = `MMSB_MODE_MICRO_CTRL,
    mode_extended   = `MMSB_MODE_EXTENDED,
    mode_protected  = `MMSB_MODE_PROTECTED
  } mmsb_mode_t;
  // gray order along the instruction cycle
  typedef enum logic [1:0] {
    ph_q1 = 2'h0,
    ph_q2 = 2'h1,
    ph_q3 = 2'h3,
    ph_q4 = 2'h2
  } mmsb_phase_t;
  typedef enum logic [2:0] {
    op_none, op_read, op_write, op_move_periph_to_file,
    op_move_file_to_periph, op_load_ram_bank_literal
  } mmsb_op_t;
endpackage

// ==== rtl/mmsb_dmem_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface mmsb_dmem_if;
  mmsb_pkg::mmsb_op_t op;
  logic [7:0]         addr_a;
  logic [7:0]         addr_b;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  logic [7:0]         bank;
  logic               done;
  modport cpu (output op, addr_a, addr_b, wdata, input rdata, bank, done);
  modport mem (input op, addr_a, addr_b, wdata, output rdata, bank, done);
endinterface
`default_nettype wire

// ==== rtl/mmsb_data_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mmsb_defines.svh"
module mmsb_data_mem (
  input wire logic clock_in,
  input wire logic nrst_in,
  mmsb_dmem_if.mem dm
);
  import mmsb_pkg::*;
  logic [7:0] ram [0:`MMSB_RAM_WORDS-1];
  logic [7:0] bank_q, bank_d, ptr0_q, ptr0_d, ptr1_q, ptr1_d, rdata_q, rdata_d;
  logic       done_q, done_d, wr_en;
  logic [8:0] wr_idx;
  logic [7:0] wr_val, src, dst, val;

  // ****************************************
  // address decode
  // ****************************************
  // pointer slots turn into the pointed-to file address
  function automatic logic [7:0] eff(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
    if (a == `MMSB_INDIR0_ADDR) return p0;
    if (a == `MMSB_INDIR1_ADDR) return p1;
    return a;
  endfunction
  // bank bits only matter inside the banked windows
  function automatic logic [8:0] phys(input logic [7:0] a, input logic [7:0] b);
    if (a >= `MMSB_CTL_BANK_LO && a <= `MMSB_CTL_BANK_HI)
      return `MMSB_CTL_BANK_BASE | {4'h0, b[1:0], a[2:0]};
    if (a >= `MMSB_SCRATCH_BASE)
      return {b[`MMSB_RAM_BANK_BIT], a};
    return {1'b0, a};
  endfunction

  // ****************************************
  // operation decode
  // ****************************************
  // peripheral side masked to its range, file side spans the whole map
  always_comb begin
    src = 8'h00;
    dst = 8'h00;
    case (dm.op)
      op_move_periph_to_file: begin
        src = eff(dm.addr_a & `MMSB_PERIPH_MAX, ptr0_q, ptr1_q);
        dst = eff(dm.addr_b & `MMSB_FILE_MAX, ptr0_q, ptr1_q);
      end
      op_move_file_to_periph: begin
        src = eff(dm.addr_b & `MMSB_FILE_MAX, ptr0_q, ptr1_q);
        dst = eff(dm.addr_a & `MMSB_PERIPH_MAX, ptr0_q, ptr1_q);
      end
      default: begin
        src = eff(dm.addr_a, ptr0_q, ptr1_q);
        dst = src;
      end
    endcase
    if (src == `MMSB_PTR0_ADDR)
      val = ptr0_q;
    else if (src == `MMSB_PTR1_ADDR)
      val = ptr1_q;
    else if (src == `MMSB_BANKSEL_ADDR)
      val = bank_q;
    else
      val = ram[phys(src, bank_q)];
  end

  // next values of registers, read data and the array write port
  always_comb begin
    bank_d  = bank_q;
    ptr0_d  = ptr0_q;
    ptr1_d  = ptr1_q;
    rdata_d = rdata_q;
    done_d  = dm.op != op_none;
    wr_en   = 1'b0;
    wr_val  = (dm.op == op_write) ? dm.wdata : val;
    wr_idx  = phys(dst, bank_q);
    case (dm.op)
      op_read: rdata_d = val;
      op_load_ram_bank_literal: bank_d[7:4] = dm.wdata[3:0];
      op_write, op_move_periph_to_file, op_move_file_to_periph: begin
        rdata_d = wr_val;
        if (dst == `MMSB_PTR0_ADDR)
          ptr0_d = wr_val;
        else if (dst == `MMSB_PTR1_ADDR)
          ptr1_d = wr_val;
        else if (dst == `MMSB_BANKSEL_ADDR)
          bank_d = wr_val;
        else
          wr_en = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_q  <= `MMSB_BANKSEL_RST;
      ptr0_q  <= `MMSB_PTR_RST;
      ptr1_q  <= `MMSB_PTR_RST;
      rdata_q <= 8'h00;
      done_q  <= 1'b0;
    end else begin
      bank_q  <= bank_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  // no reset on the array: contents survive every reset
  always_ff @(posedge clock_in) begin
    if (wr_en) ram[wr_idx] <= wr_val;
  end

  assign dm.rdata = rdata_q;
  assign dm.bank  = bank_q;
  assign dm.done  = done_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_ram_bank_load;
    dm.op == op_load_ram_bank_literal |=> bank_q[7:4] == $past(dm.wdata[3:0]) && done_q;
  endproperty
  a_ram_bank_load: assert property (p_ram_bank_load) else $error("ram bank not loaded");
  property p_write_readback;
    dm.op == op_write ##1 dm.op == op_read && $past(dm.addr_a) == dm.addr_a
      && $past(bank_q) == bank_q && $past(ptr0_q) == ptr0_q && $past(ptr1_q) == ptr1_q
      |=> rdata_q == $past(dm.wdata, 2);
  endproperty
  a_write_readback: assert property (p_write_readback) else $error("write not read back");
endmodule // mmsb_data_mem
`default_nettype wire

// ==== rtl/mmsb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mmsb_defines.svh"
module mmsb_top (
  input  wire logic               clock_in,
  input  wire logic               nrst_in,
  input  wire logic [1:0]         cfg_mode_in,
  input  wire logic               fetch_req_in,
  input  wire logic               fetch_we_in,
  input  wire logic [15:0]        fetch_addr_in,
  input  wire logic [15:0]        fetch_wdata_in,
  output logic                    fetch_ready_out,
  output logic                    fetch_done_out,
  output logic [15:0]             fetch_data_out,
  output logic                    fetch_ext_out,
  output logic                    fetch_denied_out,
  output logic                    int_rd_out,
  output logic [15:0]             int_addr_out,
  input  wire logic [15:0]        int_data_in,
  output logic                    bus_mode_out,
  input  wire mmsb_pkg::mmsb_op_t dm_op_in,
  input  wire logic [7:0]         dm_addr_a_in,
  input  wire logic [7:0]         dm_addr_b_in,
  input  wire logic [7:0]         dm_wdata_in,
  output logic [7:0]              dm_rdata_out,
  output logic                    dm_done_out,
  output logic [7:0]              bank_selector_out,
  input  wire logic [7:0]         third_io_port_group_in,
  output logic [7:0]              third_io_port_group_out,
  output logic [7:0]              third_io_port_group_oe_out,
  input  wire logic [7:0]         third_io_user_out_in,
  input  wire logic [7:0]         third_io_user_oe_in,
  input  wire logic [7:0]         fourth_io_port_group_in,
  output logic [7:0]              fourth_io_port_group_out,
  output logic [7:0]              fourth_io_port_group_oe_out,
  input  wire logic [7:0]         fourth_io_user_out_in,
  input  wire logic [7:0]         fourth_io_user_oe_in,
  output logic [2:0]              fifth_io_port_group_out,
  output logic [2:0]              fifth_io_port_group_oe_out,
  input  wire logic [2:0]         fifth_io_user_out_in,
  input  wire logic [2:0]         fifth_io_user_oe_in
);
  import mmsb_pkg::*;

  mmsb_mode_t  mode_q, mode_d;
  mmsb_phase_t phase_q, phase_d;
  logic        cap_q, cap_d;
  logic        act_q, act_d, we_q, we_d, int_q, int_d, show_q, show_d;
  logic        done_q, done_d, ext_q, ext_d, den_q, den_d;
  logic [15:0] addr_q, addr_d, wdat_q, wdat_d, data_q, data_d;
  logic        ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, ad_oe_q, ad_oe_d;
  logic [15:0] ad_q, ad_d;
  logic        take, use_int, use_ext, bus_on;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic in_int(input logic [15:0] a);
    return a < `MMSB_INT_PROG_WORDS;
  endfunction
  function automatic logic in_cfg(input logic [15:0] a);
    return a >= `MMSB_CFG_BASE;
  endfunction
  function automatic logic bus_mode(input mmsb_mode_t m);
    return m == mode_micro_proc || m == mode_extended;
  endfunction
  function automatic logic int_ok(input mmsb_mode_t m);
    return m != mode_micro_proc;
  endfunction
  function automatic logic cfg_ok(input mmsb_mode_t m);
    return m == mode_micro_ctrl || m == mode_protected;
  endfunction

  // ****************************************
  // processor mode
  // ****************************************
  // mode sits at fully external until the config bits are caught after release
  always_comb begin
    mode_d = mode_q;
    cap_d  = 1'b1;
    if (!cap_q) mode_d = mmsb_mode_t'(cfg_mode_in);
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= mode_micro_proc;
      cap_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cap_q  <= cap_d;
    end
  end

  // ****************************************
  // instruction cycle phases
  // ****************************************
  always_comb begin
    case (phase_q)
      ph_q1:   phase_d = ph_q2;
      ph_q2:   phase_d = ph_q3;
      ph_q3:   phase_d = ph_q4;
      ph_q4:   phase_d = ph_q1;
      default: phase_d = ph_q1;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) phase_q <= ph_q1;
    else phase_q <= phase_d;
  end

  // ****************************************
  // access sequencer
  // ****************************************
  // requests are only taken at the cycle boundary so each access owns a whole cycle
  assign fetch_ready_out = cap_q && phase_q == ph_q4;
  assign take            = fetch_ready_out && fetch_req_in;
  assign bus_on          = bus_mode(mode_q);
  // fixed window on-chip; in extended mode everything above it goes out
  assign use_int = int_ok(mode_q) && (in_int(fetch_addr_in) || (in_cfg(fetch_addr_in) && cfg_ok(mode_q)));
  assign use_ext = bus_on && !use_int;

  always_comb begin
    act_d  = act_q;
    we_d   = we_q;
    int_d  = int_q;
    show_d = show_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    data_d = data_q;
    ext_d  = ext_q;
    den_d  = den_q;
    done_d = 1'b0;
    if (act_q && phase_q == ph_q4) begin
      act_d  = 1'b0;
      done_d = 1'b1;
      // mirrored external data is dropped while running from inside
      if (int_q && !we_q)
        data_d = int_data_in;
      else if (ext_q && !we_q)
        data_d = {fourth_io_port_group_in, third_io_port_group_in};
      else if (!we_q)
        data_d = `MMSB_WORD_RST;
    end
    if (take) begin
      act_d  = 1'b1;
      we_d   = fetch_we_in;
      int_d  = use_int;
      ext_d  = use_ext;
      den_d  = in_cfg(fetch_addr_in) && !cfg_ok(mode_q);
      addr_d = fetch_addr_in;
      wdat_d = fetch_wdata_in;
      // internal writes are not mirrored; internal reads are in extended mode
      show_d = use_ext || (bus_on && use_int && !fetch_we_in);
    end
  end

  // ****************************************
  // bus pins, registered from next phase
  // ****************************************
  // address only in Q1 with the latch strobe, Q2 left idle for turnaround
  always_comb begin
    ale_d   = act_d && show_d && phase_d == ph_q1;
    ad_oe_d = act_d && show_d && (phase_d == ph_q1
              || (we_d && (phase_d == ph_q3 || phase_d == ph_q4)));
    ad_d    = (phase_d == ph_q1) ? addr_d : wdat_d;
    rd_n_d  = !(act_d && show_d && !we_d && (phase_d == ph_q3 || phase_d == ph_q4));
    wr_n_d  = !(act_d && show_d && we_d && phase_d == ph_q3);
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      act_q   <= 1'b0;
      we_q    <= 1'b0;
      int_q   <= 1'b0;
      show_q  <= 1'b0;
      ext_q   <= 1'b0;
      den_q   <= 1'b0;
      done_q  <= 1'b0;
      addr_q  <= `MMSB_WORD_RST;
      wdat_q  <= `MMSB_WORD_RST;
      data_q  <= `MMSB_WORD_RST;
      ale_q   <= 1'b0;
      ad_oe_q <= 1'b0;
      ad_q    <= `MMSB_WORD_RST;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
    end else begin
      act_q   <= act_d;
      we_q    <= we_d;
      int_q   <= int_d;
      show_q  <= show_d;
      ext_q   <= ext_d;
      den_q   <= den_d;
      done_q  <= done_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      data_q  <= data_d;
      ale_q   <= ale_d;
      ad_oe_q <= ad_oe_d;
      ad_q    <= ad_d;
      rd_n_q  <= rd_n_d;
      wr_n_q  <= wr_n_d;
    end
  end

  assign fetch_done_out   = done_q;
  assign fetch_data_out   = data_q;
  assign fetch_ext_out    = ext_q;
  assign fetch_denied_out = den_q;
  assign int_rd_out       = act_q && int_q && !we_q;
  assign int_addr_out     = addr_q;
  assign bus_mode_out     = bus_on;

  // ****************************************
  // port reassignment
  // ****************************************
  // in bus modes the user drive is shut out entirely
  always_comb begin
    if (bus_on) begin
      third_io_port_group_out     = ad_q[7:0];
      third_io_port_group_oe_out  = {8{ad_oe_q}};
      fourth_io_port_group_out    = ad_q[15:8];
      fourth_io_port_group_oe_out = {8{ad_oe_q}};
      fifth_io_port_group_out     = {wr_n_q, rd_n_q, ale_q};
      fifth_io_port_group_oe_out  = 3'h7;
    end else begin
      third_io_port_group_out     = third_io_user_out_in;
      third_io_port_group_oe_out  = third_io_user_oe_in;
      fourth_io_port_group_out    = fourth_io_user_out_in;
      fourth_io_port_group_oe_out = fourth_io_user_oe_in;
      fifth_io_port_group_out     = fifth_io_user_out_in;
      fifth_io_port_group_oe_out  = fifth_io_user_oe_in;
    end
  end

  // ****************************************
  // data memory, never routed to the bus
  // ****************************************
  mmsb_dmem_if dm_bus ();
  assign dm_bus.op     = dm_op_in;
  assign dm_bus.addr_a = dm_addr_a_in;
  assign dm_bus.addr_b = dm_addr_b_in;
  assign dm_bus.wdata  = dm_wdata_in;
  assign dm_rdata_out      = dm_bus.rdata;
  assign dm_done_out       = dm_bus.done;
  assign bank_selector_out = dm_bus.bank;

  mmsb_data_mem u_dmem (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .dm       (dm_bus.mem)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence s_addr_phase;
    ale_q && ad_oe_q ##1 !ale_q && !ad_oe_q;
  endsequence
  sequence s_read_data;
    !rd_n_q && wr_n_q ##1 !rd_n_q ##1 rd_n_q;
  endsequence
  sequence s_write_data;
    !wr_n_q && ad_oe_q ##1 wr_n_q && ad_oe_q ##1 !ad_oe_q || ale_q;
  endsequence
  property p_read_cycle;
    take && !fetch_we_in && bus_on && (use_ext || use_int) |=> s_addr_phase ##1 s_read_data;
  endproperty
  a_read_cycle: assert property (p_read_cycle) else $error("bad read cycle");
  property p_write_cycle;
    take && fetch_we_in && use_ext |=> s_addr_phase ##1 s_write_data;
  endproperty
  a_write_cycle: assert property (p_write_cycle) else $error("bad write cycle");
  property p_mp_no_internal;
    mode_q == mode_micro_proc |-> !int_rd_out;
  endproperty
  a_mp_no_internal: assert property (p_mp_no_internal) else $error("internal read in fully external mode");
  property p_cfg_gate;
    int_rd_out && in_cfg(int_addr_out) |-> cfg_ok(mode_q);
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config area reached in wrong mode");
  property p_reset_mode;
    !cap_q |-> mode_q == mode_micro_proc;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not fully external at start");
  property p_bus_ports;
    bus_on |-> fifth_io_port_group_oe_out == 3'h7 && fifth_io_port_group_out[0] == ale_q
      && (act_q || fifth_io_port_group_out == 3'h6);
  endproperty
  a_bus_ports: assert property (p_bus_ports) else $error("strobe port not assigned");
  property p_ext_mirror;
    take && mode_q == mode_extended && use_int && !fetch_we_in |=> ale_q && int_rd_out ##4 fetch_done_out;
  endproperty
  a_ext_mirror: assert property (p_ext_mirror) else $error("internal fetch not mirrored");
  property p_no_fight;
    !rd_n_q |-> !ad_oe_q && !ale_q;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus driven during read data");
  property p_data_local;
    dm_op_in != op_none && !act_q && !take |=> !ale_q && rd_n_q && wr_n_q;
  endproperty
  a_data_local: assert property (p_data_local) else $error("data access seen on bus");
endmodule // mmsb_top
`default_nettype wire

// ==== verification/mmsb_ext_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// external program memory behind an address latch
// ****************************************
module mmsb_ext_mem (
  input  wire logic        clock_in,
  input  wire logic        ale_in,
  input  wire logic        nrd_in,
  input  wire logic        nwr_in,
  input  wire logic        slow_in,
  input  wire logic [15:0] dev_ad_in,
  input  wire logic [15:0] dev_oe_in,
  output logic      [15:0] bus_out,
  output logic             conflict_out
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0]  lat_q;
  logic        late_q;
  logic        drive;
  // start from a pattern the bench can predict
  initial for (int i = 0; i < 256; i++) mem[i] = {8'(i), ~8'(i)};
  // address caught while the latch strobe is high, write taken while the write strobe is low
  always @(posedge clock_in) begin
    if (ale_in) lat_q <= bus_out[7:0];
    if (!nwr_in) mem[lat_q] <= bus_out;
    late_q <= ~nrd_in;
    last_q <= bus_out;
  end
  // slow answer comes one clock late, still inside the read window
  assign drive = ~nrd_in & (~slow_in | late_q);
  // a released line shows the inverse of its last level, not a held value
  assign bus_out = (dev_oe_in & dev_ad_in) | (~dev_oe_in & (drive ? mem[lat_q] : ~last_q));
  assign conflict_out = drive & (|dev_oe_in);
endmodule // mmsb_ext_mem
`default_nettype wire

// ==== verification/test_memory_mode_and_system_bus.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_memory_mode_and_system_bus;
  import mmsb_pkg::*;
  // ****************************************
  // stimulus, observation and expectations
  // ****************************************
  logic       clock_in = 1'b0, nrst_in = 1'b0, req = 1'b0, we = 1'b0, slow = 1'b0;
  mmsb_mode_t mode = mode_micro_proc;
  mmsb_op_t   op = op_none;
  logic [15:0] fa = 16'h0000, fw = 16'h0000, data, iaddr, ad, ad_oe, bus;
  logic [7:0] da = 8'h00, db = 8'h00, dw = 8'h00, u3 = 8'h00, u3e = 8'h00, u4 = 8'h00, u4e = 8'h00;
  logic [7:0] rdata, bsel, p3, p3e, p4, p4e;
  logic [2:0] u5 = 3'h6, u5e = 3'h0, p5, p5e;
  logic       rdy, done, ext, deny, ird, bmode, ddone, clash;
  logic [15:0] xm [256];
  logic [15:0] corner [4] = '{16'h07ff, 16'h0800, 16'hfe00, 16'hffff};
  mmsb_mode_t mt [4] = '{mode_micro_proc, mode_micro_ctrl, mode_extended, mode_protected};
  int         fail_count = 0, checks = 0, seed = 32'h7e85, cyc = 0;

  always #2 clock_in = ~clock_in;
  assign ad = {p4, p3};
  assign ad_oe = {p4e, p3e};

  mmsb_top mmsb_top_i (.clock_in(clock_in), .nrst_in(nrst_in), .cfg_mode_in(mode), .fetch_req_in(req),
    .fetch_we_in(we), .fetch_addr_in(fa), .fetch_wdata_in(fw), .fetch_ready_out(rdy), .fetch_done_out(done),
    .fetch_data_out(data), .fetch_ext_out(ext), .fetch_denied_out(deny), .int_rd_out(ird),
    .int_addr_out(iaddr), .int_data_in(iaddr ^ 16'ha5c3), .bus_mode_out(bmode), .dm_op_in(op),
    .dm_addr_a_in(da), .dm_addr_b_in(db), .dm_wdata_in(dw), .dm_rdata_out(rdata), .dm_done_out(ddone),
    .bank_selector_out(bsel), .third_io_port_group_in(bus[7:0]), .third_io_port_group_out(p3),
    .third_io_port_group_oe_out(p3e), .third_io_user_out_in(u3), .third_io_user_oe_in(u3e),
    .fourth_io_port_group_in(bus[15:8]), .fourth_io_port_group_out(p4), .fourth_io_port_group_oe_out(p4e),
    .fourth_io_user_out_in(u4), .fourth_io_user_oe_in(u4e), .fifth_io_port_group_out(p5),
    .fifth_io_port_group_oe_out(p5e), .fifth_io_user_out_in(u5), .fifth_io_user_oe_in(u5e));

  mmsb_ext_mem mmsb_ext_mem_i (.clock_in(clock_in), .ale_in(p5[0]), .nrd_in(p5[1]), .nwr_in(p5[2]),
    .slow_in(slow), .dev_ad_in(ad), .dev_oe_in(ad_oe), .bus_out(bus), .conflict_out(clash));

  // expected target, denial and word of one program access
  function automatic logic ext_f(input logic [15:0] a);
    return mode == mode_micro_proc || (mode == mode_extended && a >= 16'h0800);
  endfunction
  function automatic logic deny_f(input logic [15:0] a);
    return a >= 16'hfe00 && (mode == mode_micro_proc || mode == mode_extended);
  endfunction
  function automatic logic [15:0] exp_f(input logic [15:0] a);
    return ext_f(a) ? xm[a[7:0]] : ((a < 16'h0800 || a >= 16'hfe00) ? a ^ 16'ha5c3 : 16'h0000);
  endfunction

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic close_out;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // reset with the mode strapped; the device must show the bus mode meanwhile
  task automatic rst(input mmsb_mode_t m);
    nrst_in = 1'b0;
    mode = m;
    repeat (12) @(negedge clock_in);
    cmp_flag(bmode, 1'b1);
    nrst_in = 1'b1;
    @(negedge clock_in);
  endtask

  // one program access, taken at a Q4 edge, watched through its four phases
  task automatic fetch(input logic w, input logic [15:0] a, input logic [15:0] d);
    logic sa, sr, si, sc;
    int n;
    n = 0; sa = 0; sr = 0; si = 0; sc = 0;
    while (rdy !== 1'b1 && n < 8) begin
      @(negedge clock_in);
      n++;
    end
    req = 1'b1; we = w; fa = a; fw = d;
    @(negedge clock_in);
    req = 1'b0;
    for (int i = 1; i < 5; i++) begin
      sa |= p5[0]; sr |= ~p5[1]; si |= ird; sc |= clash;
      cmp_flag(done, 1'b0);
      cmp_flag(rdy, i == 4);
      if (i == 1) cmp(iaddr, a);
      if (i == 1 && bmode && (ext_f(a) || !w)) cmp(ad, a);
      if (i == 3 && !w && bmode) cmp(ad_oe, 16'h0000);
      if (i == 3 && w && ext_f(a)) cmp(ad, d);
      @(negedge clock_in);
    end
    cmp_flag(done, 1'b1);
    cmp_flag(ext, ext_f(a));
    cmp_flag(deny, deny_f(a));
    cmp_flag(sc, 1'b0);
    if (!w && bmode) cmp({14'h0000, sa, sr}, 16'h0003);
    if (!w) cmp_flag(si, !ext_f(a) && (a < 16'h0800 || a >= 16'hfe00));
    if (!w) cmp(data, exp_f(a));
    if (w && ext_f(a)) xm[a[7:0]] = d;
  endtask

  // one data-memory op, held for a single cycle so ops run back to back
  task automatic dmop(input mmsb_op_t o, input logic [7:0] a, b, w, e);
    op = o; da = a; db = b; dw = w;
    @(negedge clock_in);
    cmp_flag(ddone, 1'b1);
    if (o != op_load_ram_bank_literal) cmp({8'h00, rdata}, {8'h00, e});
    if (bmode) cmp({13'h0000, p5}, 16'h0006);
  endtask

  // a hung handshake ends the run here instead of spinning
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) xm[i] = {8'(i), ~8'(i)};
    rst(mode_micro_proc);
    dmop(op_write, 8'h20, 8'h00, 8'h5a, 8'h5a);
    dmop(op_load_ram_bank_literal, 8'h00, 8'h00, 8'h01, 8'h00);
    dmop(op_write, 8'h20, 8'h00, 8'ha3, 8'ha3);
    cmp_flag(bsel[4], 1'b1);
    dmop(op_write, 8'h18, 8'h00, 8'h77, 8'h77);
    dmop(op_load_ram_bank_literal, 8'h00, 8'h00, 8'h00, 8'h00);
    dmop(op_read, 8'h20, 8'h00, 8'h00, 8'h5a);
    dmop(op_read, 8'h18, 8'h00, 8'h00, 8'h77);
    dmop(op_move_periph_to_file, 8'h18, 8'h40, 8'h00, 8'h77);
    dmop(op_move_file_to_periph, 8'h39, 8'h20, 8'h00, 8'h5a);
    dmop(op_read, 8'h19, 8'h00, 8'h00, 8'h5a);
    dmop(op_read, 8'h40, 8'h00, 8'h00, 8'h77);
    dmop(op_write, 8'h01, 8'h00, 8'h20, 8'h20);
    dmop(op_read, 8'h00, 8'h00, 8'h00, 8'h5a);
    dmop(op_write, 8'h09, 8'h00, 8'h40, 8'h40);
    dmop(op_read, 8'h08, 8'h00, 8'h00, 8'h77);
    dmop(op_write, 8'h10, 8'h00, 8'h3c, 8'h3c);
    dmop(op_write, 8'h0f, 8'h00, 8'h11, 8'h11);
    cmp({8'h00, bsel}, 16'h0011);
    dmop(op_write, 8'h10, 8'h00, 8'hc3, 8'hc3);
    dmop(op_read, 8'h18, 8'h00, 8'h00, 8'h77);
    dmop(op_write, 8'h0f, 8'h00, 8'h00, 8'h00);
    dmop(op_read, 8'h10, 8'h00, 8'h00, 8'h3c);
    for (int i = 0; i < 4; i++) begin
      dw = 8'($random(seed));
      dmop(op_write, {1'b1, 7'(i * 29)}, 8'h00, dw, dw);
      dmop(op_read, {1'b1, 7'(i * 29)}, 8'h00, 8'h00, dw);
    end
    op = op_none;
    $display("data memory run done");
    for (int k = 0; k < 4; k++) begin
      rst(mt[k]);
      cmp({8'h00, bsel}, 16'h0000);
      dmop(op_read, 8'h20, 8'h00, 8'h00, 8'h5a);
      op = op_none;
      slow = k[0];
      u3 = 8'($random(seed)); u3e = 8'($random(seed)); u4 = 8'($random(seed)); u4e = 8'($random(seed));
      u5 = {2'b11, 1'($random(seed))}; u5e = 3'($random(seed));
      #1;
      cmp_flag(bmode, mode == mode_micro_proc || mode == mode_extended);
      if (bmode) cmp({13'h0000, p5e}, 16'h0007);
      else begin
        cmp(ad, {u4, u3});
        cmp(ad_oe, {u4e, u3e});
        cmp({13'h0000, p5}, {13'h0000, u5});
      end
      @(negedge clock_in);
      for (int j = 0; j < 4; j++) fetch(1'b0, corner[j], 16'h0000);
      fetch(1'b1, 16'h0955, 16'($random(seed)));
      fetch(1'b0, 16'h0955, 16'h0000);
      fetch(1'b1, 16'h0100, 16'h1234);
      fetch(1'b0, 16'h0100, 16'h0000);
      repeat (3) fetch(1'b0, 16'($random(seed)), 16'h0000);
      $display("mode run %0d done", k);
    end
    close_out();
  end
endmodule // test_memory_mode_and_system_bus
`default_nettype wire
